//--- rtl/icc_pkg.sv
// package of the interrupt control configuration block
// holds register offsets, field positions, reset values and widths shared by the design files
package icc_pkg;

	// ****************************************
	// register map (byte addresses, one word each)
	// ****************************************
	localparam logic [7:0] ICC_OFS_CONTROL = 8'h00;
	localparam logic [7:0] ICC_OFS_STATUS = 8'h04;
	localparam logic [7:0] ICC_OFS_MASK = 8'h08;
	localparam int ICC_ADDR_BITS = 8;

	// ****************************************
	// control register fields
	// ****************************************
	localparam int ICC_NUM_EXT = 5;
	localparam int ICC_POL_LSB = 0;
	localparam int ICC_PROX_THR_LSB = 8;
	localparam int ICC_PROX_THR_BITS = 3;
	localparam int ICC_MULTI_VEC_BIT = 12;
	localparam logic ICC_MULTI_VEC_RESET = 1'h0;
	localparam logic [2:0] ICC_PROX_THR_RESET = 3'h0;
	localparam logic [2:0] ICC_PROX_THR_OFF = 3'h0;
	localparam logic [4:0] ICC_POL_RESET = 5'h00;

	// ****************************************
	// status and mask layout
	// ****************************************
	localparam int ICC_EVT_BITS = 6;
	localparam int ICC_EVT_PROX_BIT = 5;
	localparam logic [5:0] ICC_EVT_RESET = 6'h00;

	// ****************************************
	// bus encodings
	// ****************************************
	localparam logic [1:0] ICC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] ICC_HTRANS_SEQ = 2'h3;
	localparam logic [2:0] ICC_HSIZE_WORD = 3'h2;
	localparam logic ICC_HRESP_OKAY = 1'h0;

endpackage

//--- rtl/icc_edge_detect.sv
// one external interrupt input: synchroniser and selectable edge detector
// assumes the pin is asynchronous to mclk_in; the polarity comes from the same clock domain
`timescale 1ns/1ps
`default_nettype none

module icc_edge_detect
	import icc_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic pin_in,
	input wire logic rising_in,
	output logic edge_out
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic pulse;
	} icc_edge_state_t;

	icc_edge_state_t s_reg;
	icc_edge_state_t s_next;

	// ****************************************
	// next state
	// ****************************************
	// sync1 is read only by sync2; detection looks at sync2 and its delayed copy
	always_comb begin
		s_next = s_reg;
		s_next.sync1 = pin_in;
		s_next.sync2 = s_reg.sync1;
		s_next.prev = s_reg.sync2;
		if (rising_in) begin
			s_next.pulse = s_reg.sync2 & ~s_reg.prev; // R5
		end else begin
			s_next.pulse = ~s_reg.sync2 & s_reg.prev; // R5
		end
	end

	// registers, synchronous active-low reset
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign edge_out = s_reg.pulse;

endmodule

`default_nettype wire

//--- rtl/icc_top.sv
// interrupt control configuration: control register, edge triggering, proximity timer start
// assumes a single AHB-Lite master on mclk_in and asynchronous external interrupt pins
//
// How it works
// R1: the vector configuration bit selects multi-vectored dispatch when 1 and single-vectored when 0.
// R2: a threshold N from 2 to 7 lets interrupts of group priority N or lower start the proximity timer.
// R3: a threshold of 1 lets only group priority 1 interrupts start the proximity timer.
// R4: a threshold of 0 disables the proximity timer so that nothing starts it.
// R5: each of the five external inputs has a polarity bit, 1 for rising edge and 0 for falling edge.
// R6: bits 31 to 13, bit 11 and bits 7 to 5 of the control register always read as zero.
// R7: every implemented control field clears to zero at reset.
`timescale 1ns/1ps
`default_nettype none

module icc_top
	import icc_pkg::*;
#(
	parameter int NUM_EXT = ICC_NUM_EXT
)
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// external interrupt pins
	input wire logic [NUM_EXT-1:0] ext_irq_in,
	output logic [NUM_EXT-1:0] ext_irq_edge_out,
	// interrupt requests from the priority logic
	input wire logic irq_req_in,
	input wire logic [2:0] irq_group_prio_in,
	output logic prox_timer_start_out,
	output logic prox_timer_enable_out,
	// dispatch mode and interrupt line
	output logic multi_vector_select_out,
	output logic irq_out
);

	// ****************************************
	// elaboration check
	// ****************************************
	// the register layout has room for exactly five polarity bits
	if (NUM_EXT < 1 || NUM_EXT > ICC_NUM_EXT) begin : g_bad_num_ext
		$error("NUM_EXT must lie between 1 and 5");
	end

	typedef struct packed {
		logic multi_vector_select;
		logic [ICC_PROX_THR_BITS-1:0] proximity_timer_threshold;
		logic [ICC_NUM_EXT-1:0] edge_polarity;
		logic [ICC_EVT_BITS-1:0] status;
		logic [ICC_EVT_BITS-1:0] mask;
		logic wr_pending;
		logic [ICC_ADDR_BITS-1:0] wr_addr;
		logic [31:0] rdata;
		logic prox_start;
	} icc_state_t;

	icc_state_t s_reg;
	icc_state_t s_next;

	logic [NUM_EXT-1:0] edge_pulse;
	logic [ICC_EVT_BITS-1:0] evt_set;
	logic [ICC_EVT_BITS-1:0] evt_clr;
	logic addr_phase;
	logic prox_hit;
	logic [ICC_NUM_EXT-1:0] ext_edges;

	// ****************************************
	// external input edge detectors
	// ****************************************
	// polarity is read from the register every cycle, so a new setting applies at once
	for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
		icc_edge_detect u_edge (
			.mclk_in(mclk_in),
			.resetn_in(resetn_in),
			.pin_in(ext_irq_in[i]),
			.rising_in(s_reg.edge_polarity[ICC_POL_LSB + i]),
			.edge_out(edge_pulse[i])
		);
	end

	// unbuilt inputs never raise an event
	always_comb begin
		ext_edges = '0;
		ext_edges[NUM_EXT-1:0] = edge_pulse;
	end

	// ****************************************
	// proximity timer start decision
	// ****************************************
	// priority 0 is taken as "not an interrupt" and never starts the timer
	always_comb begin
		prox_hit = 1'b0;
		if (s_reg.proximity_timer_threshold == ICC_PROX_THR_OFF) begin
			prox_hit = 1'b0; // R4
		end else if (irq_req_in && irq_group_prio_in != 3'h0) begin
			// threshold 1 reduces to priority 1 only, N reaches N and below
			prox_hit = irq_group_prio_in <= s_reg.proximity_timer_threshold; // R2 R3
		end
	end

	// ****************************************
	// bus decode and event bookkeeping
	// ****************************************
	// transfer accepted on this edge; IDLE and BUSY leave the registers alone
	assign addr_phase = hsel_in && hready_in
		&& (htrans_in == ICC_HTRANS_NONSEQ || htrans_in == ICC_HTRANS_SEQ);

	always_comb begin
		evt_set = '0;
		evt_set[ICC_EVT_PROX_BIT] = prox_hit;
		evt_set[ICC_NUM_EXT-1:0] = ext_edges;
		evt_clr = '0;
		if (s_reg.wr_pending && s_reg.wr_addr == ICC_OFS_STATUS) begin
			evt_clr = hwdata_in[ICC_EVT_BITS-1:0];
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.prox_start = prox_hit;
		// a new event beats a software clear in the same cycle
		s_next.status = (s_reg.status & ~evt_clr) | evt_set;
		// data phase of a write lands here
		if (s_reg.wr_pending) begin
			case (s_reg.wr_addr)
				ICC_OFS_CONTROL: begin
					s_next.multi_vector_select = hwdata_in[ICC_MULTI_VEC_BIT]; // R1
					s_next.proximity_timer_threshold =
						hwdata_in[ICC_PROX_THR_LSB +: ICC_PROX_THR_BITS];
					s_next.edge_polarity = hwdata_in[ICC_POL_LSB +: ICC_NUM_EXT]; // R5
				end
				ICC_OFS_MASK: begin
					s_next.mask = hwdata_in[ICC_EVT_BITS-1:0];
				end
				default: begin
					s_next.mask = s_reg.mask; // status handled above, others ignored
				end
			endcase
		end
		// address phase: only whole-word transfers write
		s_next.wr_pending = addr_phase && hwrite_in && hsize_in == ICC_HSIZE_WORD;
		s_next.wr_addr = {haddr_in[ICC_ADDR_BITS-1:2], 2'h0};
		// read data built from next values so a write just before is seen
		s_next.rdata = 32'h0000_0000;
		if (addr_phase && !hwrite_in) begin
			case ({haddr_in[ICC_ADDR_BITS-1:2], 2'h0})
				ICC_OFS_CONTROL: begin
					// unimplemented positions stay zero
					s_next.rdata[ICC_MULTI_VEC_BIT] = s_next.multi_vector_select; // R6
					s_next.rdata[ICC_PROX_THR_LSB +: ICC_PROX_THR_BITS] =
						s_next.proximity_timer_threshold; // R6
					s_next.rdata[ICC_POL_LSB +: ICC_NUM_EXT] = s_next.edge_polarity; // R6
				end
				ICC_OFS_STATUS: begin
					s_next.rdata[ICC_EVT_BITS-1:0] = s_next.status;
				end
				ICC_OFS_MASK: begin
					s_next.rdata[ICC_EVT_BITS-1:0] = s_next.mask;
				end
				default: begin
					s_next.rdata = 32'h0000_0000; // unmapped reads as zero
				end
			endcase
		end
		// outside the address range the upper address bits must be zero
		if (haddr_in[31:ICC_ADDR_BITS] != '0) begin
			s_next.wr_pending = 1'b0;
			s_next.rdata = 32'h0000_0000;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	// synchronous reset leaves single-vector mode, timer off, falling edges
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			s_reg.multi_vector_select <= ICC_MULTI_VEC_RESET; // R7
			s_reg.proximity_timer_threshold <= ICC_PROX_THR_RESET; // R7
			s_reg.edge_polarity <= ICC_POL_RESET; // R7
			s_reg.status <= ICC_EVT_RESET;
			s_reg.mask <= ICC_EVT_RESET;
			// no half transfer survives a reset
			s_reg.wr_pending <= 1'b0;
			s_reg.wr_addr <= '0;
			s_reg.rdata <= 32'h0000_0000;
			s_reg.prox_start <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hrdata_out = s_reg.rdata;
	assign hreadyout_out = 1'b1; // zero wait states
	// never an error: unmapped places simply read zero
	assign hresp_out = ICC_HRESP_OKAY;
	assign ext_irq_edge_out = edge_pulse;
	assign prox_timer_start_out = s_reg.prox_start;
	// enable follows the stored threshold alone, not the request lines
	assign prox_timer_enable_out = s_reg.proximity_timer_threshold != ICC_PROX_THR_OFF; // R4
	assign multi_vector_select_out = s_reg.multi_vector_select; // R1
	assign irq_out = |(s_reg.status & s_reg.mask);

endmodule

`default_nettype wire

//--- tb/icc_props.sv
// checker of the interrupt control configuration block
// bound into icc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module icc_props
	import icc_pkg::*;
#(parameter int NUM_EXT = ICC_NUM_EXT)
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic [NUM_EXT-1:0] ext_irq_edge_out,
	input wire logic irq_req_in,
	input wire logic [2:0] irq_group_prio_in,
	input wire logic prox_timer_start_out,
	input wire logic prox_timer_enable_out,
	input wire logic multi_vector_select_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	// address phase aimed at the control word
	sequence ctl_sq(w);
		hsel_in && hready_in && htrans_in[1] && hwrite_in == w && haddr_in == 32'h0
			&& (!w || hsize_in == ICC_HSIZE_WORD);
	endsequence
	a_vector_write: assert property (ctl_sq(1) ##1 1
		|=> multi_vector_select_out == $past(hwdata_in[12]))
		else $error("vector mode does not follow the written bit");
	a_prox_enable: assert property (ctl_sq(1) ##1 1
		|=> prox_timer_enable_out == ($past(hwdata_in[10:8]) != 3'h0))
		else $error("timer enable does not follow threshold");
	a_prox_off: assert property (!prox_timer_enable_out && irq_req_in |=> !prox_timer_start_out)
		else $error("timer started while disabled");
	a_prox_cause: assert property (prox_timer_start_out |-> $past(irq_req_in)
		&& $past(irq_group_prio_in) != 3'h0 && $past(prox_timer_enable_out))
		else $error("timer start without a qualifying request");
	a_edge_pulse: assert property (|ext_irq_edge_out
		|=> (ext_irq_edge_out & $past(ext_irq_edge_out)) == '0)
		else $error("edge pulse longer than one cycle");
	a_rsvd_zero: assert property (ctl_sq(0) |=> (hrdata_out & 32'hFFFF_E8E0) == 32'h0)
		else $error("unimplemented control bits read nonzero");
	a_reset_clear: assert property ($rose(resetn_in)
		|-> !multi_vector_select_out && !prox_timer_enable_out)
		else $error("control outputs not cleared by reset");
endmodule
bind icc_top icc_props #(.NUM_EXT(NUM_EXT)) i_props (.*);
`default_nettype wire

//--- tb/icc_far_model.sv
// far side model: external interrupt pins and the core's request lines
// changes its outputs just after mclk_in rising edges
`timescale 1ns/1ps
`default_nettype none
module icc_far_model
	import icc_pkg::*;
(
	input wire logic mclk_in,
	output logic [ICC_NUM_EXT-1:0] ext_irq_out,
	output logic irq_req_out,
	output logic [2:0] prio_out
);
	initial begin
		ext_irq_out = '0;
		irq_req_out = 1'b0;
		prio_out = 3'h0;
	end
	// pins held ten cycles, well over the two-period minimum the synchroniser needs
	task automatic set_pins(input logic [ICC_NUM_EXT-1:0] v);
		@(posedge mclk_in);
		ext_irq_out <= v;
		repeat (10) @(posedge mclk_in);
	endtask
	// one-cycle request; priority then inverted so a stale value never looks valid
	task automatic request(input logic [2:0] p);
		@(posedge mclk_in);
		irq_req_out <= 1'b1;
		prio_out <= p;
		@(posedge mclk_in);
		irq_req_out <= 1'b0;
		prio_out <= ~p;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench of the interrupt control configuration block
// one AHB-Lite master, the far side model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import icc_pkg::*;
	logic mclk_in, resetn_in, hsel_in, hwrite_in, irq_req_in;
	logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
	logic [1:0] htrans_in;
	logic [2:0] hsize_in, irq_group_prio_in;
	logic [4:0] ext_irq_in, ext_irq_edge_out, pol;
	logic hreadyout_out, hresp_out, prox_timer_start_out, prox_timer_enable_out;
	logic multi_vector_select_out, irq_out;
	wire logic hready_in = hreadyout_out;
	int n_errors = 0, n_tests = 0, cyc = 0, cnt[5] = '{5{0}};
	icc_top i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
		.hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .ext_irq_in(ext_irq_in),
		.ext_irq_edge_out(ext_irq_edge_out), .irq_req_in(irq_req_in),
		.irq_group_prio_in(irq_group_prio_in), .prox_timer_start_out(prox_timer_start_out),
		.prox_timer_enable_out(prox_timer_enable_out),
		.multi_vector_select_out(multi_vector_select_out), .irq_out(irq_out));
	icc_far_model i_far (.mclk_in(mclk_in), .ext_irq_out(ext_irq_in), .irq_req_out(irq_req_in),
		.prio_out(irq_group_prio_in));
	initial forever #2 mclk_in = ~mclk_in;
	// edge pulses counted per input, the only record of triggering
	always @(posedge mclk_in) begin
		foreach (cnt[i]) cnt[i] <= cnt[i] + ext_irq_edge_out[i];
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// single word transfer; hready is waited for, never assumed
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk_in); // launch just after an edge, whatever the caller did before
		htrans_in <= ICC_HTRANS_NONSEQ;
		haddr_in <= a;
		hwrite_in <= w;
		do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
		rd = hrdata_out;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		mclk_in = 0;
		resetn_in = 0;
		hsel_in = 1;
		htrans_in = 0;
		haddr_in = 0;
		hwrite_in = 0;
		hsize_in = ICC_HSIZE_WORD;
		hwdata_in = 0;
		repeat (16) @(posedge mclk_in);
		resetn_in <= 1'b1;
		@(posedge mclk_in);
		bus(0, 32'h0, 0);
		chk(rd, 32'h0);
		chk({multi_vector_select_out, prox_timer_enable_out, irq_out, hresp_out}, 4'h0);
		bus(1, 32'h0, 32'hFFFF_FFFF);
		bus(0, 32'h0, 0);
		chk(rd, 32'h0000_171F);
		chk(multi_vector_select_out, 1'b1);
		// every threshold against every group priority
		for (int t = 0; t < 8; t++) begin
			bus(1, 32'h0, t << 8);
			#1 chk(prox_timer_enable_out, t != 0);
			chk(multi_vector_select_out, 1'b0);
			for (int p = 0; p < 8; p++) begin
				i_far.request(p[2:0]);
				#1 chk(prox_timer_start_out, t != 0 && p != 0 && p <= t);
			end
		end
		// alternate polarity patterns; each pin rises then falls once per round
		for (int k = 0; k < 2; k++) begin
			pol = k ? 5'h0A : 5'h15;
			bus(1, 32'h0, {27'h0, pol});
			i_far.set_pins(5'h1F);
			// one pulse per pin per round: on the rise if rising, else on the fall
			for (int i = 0; i < 5; i++) chk(cnt[i], k + pol[i]);
			i_far.set_pins(5'h00);
			for (int i = 0; i < 5; i++) chk(cnt[i], k + 1);
		end
		// sticky events, masking and write-one-to-clear
		bus(0, 32'h4, 0);
		chk(rd, 32'h3F);
		chk(irq_out, 1'b0);
		bus(1, 32'h8, 32'h20);
		repeat (2) @(posedge mclk_in);
		#1 chk(irq_out, 1'b1);
		bus(1, 32'h4, 32'h3F);
		bus(0, 32'h4, 0);
		chk(rd, 32'h0);
		repeat (2) @(posedge mclk_in);
		#1 chk(irq_out, 1'b0);
		// unmapped places: writes dropped, reads zero
		bus(1, 32'h0C, 32'hFFFF_FFFF);
		bus(1, 32'h100, 32'hFFFF_FFFF);
		bus(0, 32'h0, 0);
		chk(rd, 32'h0000_000A);
		bus(0, 32'h0C, 0);
		chk(rd, 32'h0);
		bus(0, 32'h100, 0);
		chk(rd, 32'h0);
		// reset in mid-run with every field set must bring back the reset values
		bus(1, 32'h0, 32'hFFFF_FFFF);
		bus(1, 32'h8, 32'h3F);
		resetn_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		resetn_in <= 1'b1;
		@(posedge mclk_in);
		#1 chk({multi_vector_select_out, prox_timer_enable_out, irq_out}, 3'h0);
		bus(0, 32'h0, 0);
		chk(rd, 32'h0);
		bus(0, 32'h8, 0);
		chk(rd, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
